//--- hdl/sld_lamp_driver.sv
// status lamp pattern generator for the safety controller front panel
`timescale 1ns/1ps
`default_nettype none
module sld_lamp_driver #(
    parameter bit          LARGE_VARIANT = 1'b0,                   // 1: network lamp present
    parameter int unsigned HALF1_CYC     = sld_pkg::HALF1_CYC,     // half period of 1 s blink
    parameter int unsigned GRACE_CYC     = sld_pkg::GRACE_CYC      // power-up grace count
) (
    input  wire logic                      i_core_clk,  // 10 MHz clock
    input  wire logic                      i_rst,       // async reset, high
    input  wire sld_pkg::sld_state_type    i_state,     // mode and storage state
    input  wire sld_pkg::sld_unit_err_type i_unit_err,  // unit error classes
    input  wire sld_pkg::sld_comm_type     i_comm,      // link and network state
    output logic                           o_grace,     // power-up grace active
    output logic                           o_link_err_rec,  // link error recorded
    output logic                           o_net_err_rec,   // network error recorded
    output var sld_pkg::sld_lamps_type     o_lamps      // lamp colours
);

    if (HALF1_CYC < 1 || GRACE_CYC < 1) begin : g_bad_counts
        $error("sld_lamp_driver: counts must be at least one");
    end

    localparam int unsigned CW = $clog2(HALF1_CYC + 1);
    localparam int unsigned GW = $clog2(GRACE_CYC + 1);

    // ----------------------------------------
    // shared blink timebase
    // ----------------------------------------
    logic [CW-1:0] half_cnt_ff;
    logic          ph1_ff;      // toggles every 0.5 s: 1 s period
    logic          ph2_ff;      // toggles every 1 s: 2 s period
    logic          half_end;

    assign half_end = (half_cnt_ff == CW'(HALF1_CYC - 1));

    always_ff @(posedge i_core_clk or posedge i_rst) begin  // [RL23]
        if (i_rst) begin
            half_cnt_ff <= '0;
        end else if (half_end) begin
            half_cnt_ff <= '0;
        end else begin
            half_cnt_ff <= half_cnt_ff + CW'(1);
        end
    end

    always_ff @(posedge i_core_clk or posedge i_rst) begin  // [RL23]
        if (i_rst) begin
            ph1_ff <= 1'b0;
            ph2_ff <= 1'b0;
        end else if (half_end) begin
            ph1_ff <= ~ph1_ff;
            if (ph1_ff) begin
                ph2_ff <= ~ph2_ff;
            end
        end
    end

    // ----------------------------------------
    // power-up grace window
    // ----------------------------------------
    logic [GW-1:0] grace_cnt_ff;

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            grace_cnt_ff <= '0;
        end else if (grace_cnt_ff != GW'(GRACE_CYC)) begin
            grace_cnt_ff <= grace_cnt_ff + GW'(1);
        end
    end

    assign o_grace = (grace_cnt_ff != GW'(GRACE_CYC));

    // absent-unit conditions are recorded only after the grace window
    logic link_absent_err;
    logic net_absent_err;
    assign link_absent_err = i_comm.link_absent & ~o_grace;     // [RL6] [RL22]
    assign net_absent_err  = i_comm.net_absent & ~o_grace;      // [RL20]
    assign o_link_err_rec  = i_comm.link_comm_err | link_absent_err;
    assign o_net_err_rec   = i_comm.net_comm_err | net_absent_err;

    // ----------------------------------------
    // lamp decode
    // ----------------------------------------
    function automatic sld_pkg::sld_colour_type blink(
        input sld_pkg::sld_colour_type col,
        input logic                    ph
    );
        blink = ph ? col : sld_pkg::LAMP_OFF;
    endfunction

    sld_pkg::sld_lamps_type nxt_lamps;
    logic                   unit_crit;
    logic                   unit_minor;
    logic                   app_err;
    logic                   executing;

    always_comb begin
        unit_crit  = i_unit_err.hw_error | i_unit_err.watchdog_timeout | i_unit_err.critical;
        unit_minor = i_unit_err.bp_comm | i_unit_err.alloc_err | i_unit_err.bp_minor;
        app_err    = o_link_err_rec | i_comm.prog_err | i_comm.app_minor;
        executing  = (i_state.mode == sld_pkg::MODE_RUN)
                   | ((i_state.mode == sld_pkg::MODE_DEBUG) & i_state.debug_exec);
        nxt_lamps  = '{default: sld_pkg::LAMP_OFF};

        // safety-link lamp
        if (i_state.fatal) begin
            nxt_lamps.safety_link_lamp = sld_pkg::LAMP_OFF;                         // [RL5]
        end else if (LARGE_VARIANT) begin
            if (!i_comm.link_used) begin
                nxt_lamps.safety_link_lamp = sld_pkg::LAMP_OFF;                     // [RL21]
            end else if (o_link_err_rec) begin
                nxt_lamps.safety_link_lamp = blink(sld_pkg::LAMP_RED, ph1_ff);      // [RL21]
            end else if (!i_comm.link_all_up) begin
                nxt_lamps.safety_link_lamp = blink(sld_pkg::LAMP_GREEN, ph1_ff);    // [RL21] [RL22]
            end else begin
                nxt_lamps.safety_link_lamp = sld_pkg::LAMP_GREEN;                   // [RL21]
            end
        end else begin
            if (!i_state.app_stored) begin
                nxt_lamps.safety_link_lamp = ph1_ff ? sld_pkg::LAMP_RED
                                                    : sld_pkg::LAMP_GREEN;          // [RL4]
            end else if (app_err) begin
                nxt_lamps.safety_link_lamp = blink(sld_pkg::LAMP_RED, ph1_ff);      // [RL3]
            end else if (!i_comm.link_all_up) begin
                nxt_lamps.safety_link_lamp = blink(sld_pkg::LAMP_GREEN, ph1_ff);    // [RL2] [RL6]
            end else begin
                nxt_lamps.safety_link_lamp = sld_pkg::LAMP_GREEN;                   // [RL1]
            end
        end

        // network safety lamp, large variant only
        if (LARGE_VARIANT && !i_state.fatal && i_comm.net_used) begin
            if (i_comm.net_comm_err | i_comm.net_absent) begin
                nxt_lamps.network_safety_lamp = blink(sld_pkg::LAMP_RED, ph1_ff);   // [RL19] [RL20]
            end else if (!i_comm.net_all_up) begin
                nxt_lamps.network_safety_lamp = blink(sld_pkg::LAMP_GREEN, ph1_ff); // [RL18]
            end else begin
                nxt_lamps.network_safety_lamp = sld_pkg::LAMP_GREEN;                // [RL17]
            end
        end

        // unit status lamp
        if (unit_crit) begin
            nxt_lamps.unit_status_lamp = sld_pkg::LAMP_RED;                         // [RL14]
        end else if (unit_minor) begin
            nxt_lamps.unit_status_lamp = blink(sld_pkg::LAMP_RED, ph1_ff);          // [RL15]
        end else if (i_state.mode == sld_pkg::MODE_WAIT) begin
            nxt_lamps.unit_status_lamp = sld_pkg::LAMP_OFF;                         // [RL16]
        end else if ((i_state.mode == sld_pkg::MODE_INIT) | i_state.alloc_dl) begin
            nxt_lamps.unit_status_lamp = blink(sld_pkg::LAMP_GREEN, ph2_ff);        // [RL13]
        end else begin
            nxt_lamps.unit_status_lamp = sld_pkg::LAMP_GREEN;                       // [RL12]
        end

        // run lamp
        if (i_state.fatal) begin
            nxt_lamps.run_lamp = sld_pkg::LAMP_OFF;                                 // [RL9]
        end else if (executing) begin
            nxt_lamps.run_lamp = sld_pkg::LAMP_GREEN;                               // [RL7]
        end else if (i_state.mode == sld_pkg::MODE_INIT) begin
            nxt_lamps.run_lamp = blink(sld_pkg::LAMP_GREEN, ph1_ff);                // [RL8]
        end else begin
            nxt_lamps.run_lamp = sld_pkg::LAMP_OFF;                                 // [RL9]
        end

        // debug and validation lamps
        if (!i_state.fatal && i_state.mode == sld_pkg::MODE_DEBUG) begin
            nxt_lamps.debug_lamp = sld_pkg::LAMP_YELLOW;                            // [RL10]
        end
        if (!i_state.fatal && i_state.validated) begin
            nxt_lamps.valid_lamp = sld_pkg::LAMP_YELLOW;                            // [RL11]
        end
    end

    // ----------------------------------------
    // registered lamp outputs
    // ----------------------------------------
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            o_lamps <= '{default: sld_pkg::LAMP_OFF};
        end else begin
            o_lamps <= nxt_lamps;
        end
    end

endmodule
`default_nettype wire

//--- hdl/sld_pkg.sv
// constants and types for the safety status lamp driver
//
// Overview of operation
// [RL1] small variant: links up, no error, green steady
// [RL2] small variant: link down/opening, green blink 1 s
// [RL3] small variant: link/program/minor error, red blink 1 s
// [RL4] small variant: no application data, green/red alternate
// [RL5] fatal fault turns safety-link lamp off
// [RL6] small variant: 30 s grace, absent units blink green
// [RL7] program executing: run lamp steady green
// [RL8] initialization: run lamp green blink 1 s
// [RL9] program, debug stopped, fatal: run lamp off
// [RL10] debug mode: debug lamp steady yellow
// [RL11] validated data stored: validation lamp yellow
// [RL12] normal operation: unit-status lamp steady green
// [RL13] init or allocation download: green blink 2 s
// [RL14] hardware, watchdog, critical error: red steady
// [RL15] backplane minor error: unit-status red blink 1 s
// [RL16] restarting or waiting init: unit-status lamp off
// [RL17] large variant: network connections up, green steady
// [RL18] large variant: network not established, green blink
// [RL19] large variant: network error red blink, unused off
// [RL20] large variant: 30 s grace, network lamp red blink
// [RL21] large variant: safety-link lamp four-state pattern
// [RL22] large variant: 30 s grace, absent units green blink
// [RL23] one shared 50 percent timebase for all blinks
package sld_pkg;

    localparam int unsigned CLK_HZ        = 10_000_000;
    localparam int unsigned BLINK1_MS     = 1000;   // 1 s interval
    localparam int unsigned BLINK2_MS     = 2000;   // 2 s interval
    localparam int unsigned GRACE_S       = 30;     // power-up grace
    localparam int unsigned HALF1_CYC     = (CLK_HZ / 1000) * BLINK1_MS / 2;
    localparam int unsigned HALF2_DIV     = BLINK2_MS / BLINK1_MS;
    localparam int unsigned GRACE_CYC     = CLK_HZ * GRACE_S;

    // two-bit lamp colour code
    typedef enum logic [1:0] {
        LAMP_OFF    = 2'b00,
        LAMP_GREEN  = 2'b01,
        LAMP_RED    = 2'b10,
        LAMP_YELLOW = 2'b11
    } sld_colour_type;

    // operating mode of the unit
    typedef enum logic [2:0] {
        MODE_WAIT    = 3'b000,
        MODE_INIT    = 3'b001,
        MODE_PROGRAM = 3'b010,
        MODE_RUN     = 3'b011,
        MODE_DEBUG   = 3'b100
    } sld_mode_type;

    typedef struct packed {
        sld_mode_type mode;          // operating mode
        logic         debug_exec;    // debug mode with execution active
        logic         fatal;         // fatal fault
        logic         app_stored;    // application data stored
        logic         validated;     // validated data in nv memory
        logic         alloc_dl;      // allocation data downloading
    } sld_state_type;

    typedef struct packed {
        logic hw_error;              // hardware error
        logic watchdog_timeout;      // watchdog timeout
        logic critical;              // other critical error
        logic bp_comm;               // backplane comm error
        logic alloc_err;             // allocation data error
        logic bp_minor;              // other backplane minor error
    } sld_unit_err_type;

    typedef struct packed {
        logic link_used;             // safety-link comms in use
        logic link_all_up;           // all links established
        logic link_comm_err;         // link comm error
        logic link_absent;           // link fail from absent units
        logic prog_err;              // program execution error
        logic app_minor;             // other application minor error
        logic net_used;              // network safety in use
        logic net_all_up;            // network connections established
        logic net_comm_err;          // network comm error
        logic net_absent;            // network target absent
    } sld_comm_type;

    typedef struct packed {
        sld_colour_type safety_link_lamp;
        sld_colour_type network_safety_lamp;
        sld_colour_type unit_status_lamp;
        sld_colour_type run_lamp;
        sld_colour_type debug_lamp;
        sld_colour_type valid_lamp;
    } sld_lamps_type;

endpackage

//--- test/sld_lamp_properties.sv
// assertion checker for the status lamp driver
`timescale 1ns/1ps
`default_nettype none
module sld_lamp_props (
    input wire logic                      i_core_clk,     // clock
    input wire logic                      i_rst,          // reset
    input wire sld_pkg::sld_state_type    i_state,        // mode
    input wire sld_pkg::sld_unit_err_type i_unit_err,     // unit errors
    input wire sld_pkg::sld_comm_type     i_comm,         // comms
    input wire logic                      o_grace,        // grace
    input wire logic                      o_link_err_rec, // link rec
    input wire logic                      o_net_err_rec,  // net rec
    input wire sld_pkg::sld_lamps_type    o_lamps         // lamps
);
    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (i_rst);
    a_fatal_link_off: assert property (i_state.fatal |=> o_lamps.safety_link_lamp == sld_pkg::LAMP_OFF)
        else $error("link lamp lit after fatal fault");
    a_run_exec_green: assert property (!i_state.fatal && (i_state.mode == sld_pkg::MODE_RUN ||
        i_state.mode == sld_pkg::MODE_DEBUG && i_state.debug_exec) |=> o_lamps.run_lamp == sld_pkg::LAMP_GREEN)
        else $error("run lamp not green while executing");
    a_run_stop_off: assert property (i_state.fatal || i_state.mode == sld_pkg::MODE_PROGRAM ||
        i_state.mode == sld_pkg::MODE_DEBUG && !i_state.debug_exec |=> o_lamps.run_lamp == sld_pkg::LAMP_OFF)
        else $error("run lamp lit while stopped");
    a_debug_lamp_on: assert property (!i_state.fatal && i_state.mode == sld_pkg::MODE_DEBUG
        |=> o_lamps.debug_lamp == sld_pkg::LAMP_YELLOW) else $error("debug lamp dark in debug mode");
    a_debug_lamp_off: assert property (i_state.mode != sld_pkg::MODE_DEBUG
        |=> o_lamps.debug_lamp == sld_pkg::LAMP_OFF) else $error("debug lamp lit outside debug mode");
    a_valid_lamp_state: assert property (!i_state.fatal |=> o_lamps.valid_lamp ==
        ($past(i_state.validated) ? sld_pkg::LAMP_YELLOW : sld_pkg::LAMP_OFF)) else $error("valid lamp wrong");
    a_unit_red_steady: assert property ((i_unit_err.hw_error || i_unit_err.watchdog_timeout || i_unit_err.critical)
        ##1 (i_unit_err.hw_error || i_unit_err.watchdog_timeout || i_unit_err.critical)
        |-> o_lamps.unit_status_lamp == sld_pkg::LAMP_RED ##1 o_lamps.unit_status_lamp == sld_pkg::LAMP_RED)
        else $error("unit lamp not steady red");
    a_link_rec_grace: assert property (o_link_err_rec ==
        (i_comm.link_comm_err || i_comm.link_absent && !o_grace)) else $error("link error record wrong");
    a_net_rec_grace: assert property (o_net_err_rec ==
        (i_comm.net_comm_err || i_comm.net_absent && !o_grace)) else $error("net error record wrong");
    c_grace_absent: cover property (o_grace && i_comm.link_absent);
    c_run_green: cover property (o_lamps.run_lamp == sld_pkg::LAMP_GREEN);
    c_unit_red: cover property (o_lamps.unit_status_lamp == sld_pkg::LAMP_RED);
endmodule
bind sld_lamp_driver sld_lamp_props i_props (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_state(i_state),
    .i_unit_err(i_unit_err), .i_comm(i_comm), .o_grace(o_grace), .o_link_err_rec(o_link_err_rec),
    .o_net_err_rec(o_net_err_rec), .o_lamps(o_lamps));
`default_nettype wire

//--- test/sld_panel_view.sv
// operator view of the front-panel lamps
`timescale 1ns/1ps
`default_nettype none
module sld_panel_view (
    input  wire logic                  i_core_clk, // panel clock
    input  wire sld_pkg::sld_lamps_type i_lamps,    // lamp drive
    output var sld_pkg::sld_lamps_type  o_view      // colours as seen
);
    // the eye looks between edges, after the drive has settled
    always_ff @(negedge i_core_clk) begin
        o_view <= i_lamps;
    end
endmodule
`default_nettype wire

//--- test/testbench.sv
// self-checking bench for the status lamp driver
`timescale 1ns/1ps
`default_nettype none
module testbench;
    localparam sld_pkg::sld_colour_type O = sld_pkg::LAMP_OFF;
    localparam sld_pkg::sld_colour_type G = sld_pkg::LAMP_GREEN;
    localparam sld_pkg::sld_colour_type R = sld_pkg::LAMP_RED;
    localparam sld_pkg::sld_colour_type Y = sld_pkg::LAMP_YELLOW;
    logic                      clk;
    logic                      rst;
    sld_pkg::sld_state_type    st, ns;
    sld_pkg::sld_unit_err_type ue, nu;
    sld_pkg::sld_comm_type     cm, nc;
    logic [1:0]                grc, lrec, nrec;
    sld_pkg::sld_lamps_type    lmp [2];
    sld_pkg::sld_lamps_type    view [2];
    int                        err_total;
    int                        checks;
    sld_lamp_driver #(.HALF1_CYC(4), .GRACE_CYC(100)) i_sld_lamp_driver (.i_core_clk(clk),
        .i_rst(rst), .i_state(st), .i_unit_err(ue), .i_comm(cm), .o_grace(grc[0]), .o_link_err_rec(lrec[0]),
        .o_net_err_rec(nrec[0]), .o_lamps(lmp[0]));
    sld_lamp_driver #(.LARGE_VARIANT(1'b1), .HALF1_CYC(4), .GRACE_CYC(100)) i_sld_lamp_driver_big (.i_core_clk(clk),
        .i_rst(rst), .i_state(st), .i_unit_err(ue), .i_comm(cm), .o_grace(grc[1]), .o_link_err_rec(lrec[1]),
        .o_net_err_rec(nrec[1]), .o_lamps(lmp[1]));
    sld_panel_view i_panel_small (.i_core_clk(clk), .i_lamps(lmp[0]), .o_view(view[0]));
    sld_panel_view i_panel_big (.i_core_clk(clk), .i_lamps(lmp[1]), .o_view(view[1]));
    always #50 clk = ~clk;
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic got, input logic exp);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("FAIL %s exp %0d seen %0d", what, exp, got);
        end
    endtask
    task automatic base();
        ns = '0;
        ns.mode = sld_pkg::MODE_RUN;
        ns.app_stored = 1'b1;
        nu = '0;
        nc = '0;
        nc.link_used = 1'b1;
        nc.link_all_up = 1'b1;
        nc.net_used = 1'b1;
        nc.net_all_up = 1'b1;
    endtask
    // apply pending inputs, then watch one lamp: colours x/y, about tg changes in 24 cycles
    task automatic see(input bit b, input int f, input sld_pkg::sld_colour_type x, y, input int tg);
        logic [1:0] v;
        logic [1:0] p;
        int         n;
        bit         ok;
        @(posedge clk);
        st <= ns;
        ue <= nu;
        cm <= nc;
        repeat (3) @(posedge clk);
        n = 0;
        ok = 1;
        for (int k = 0; k < 24; k++) begin
            @(negedge clk);
            v = 2'(view[b] >> (10 - 2 * f));
            if (k > 0 && v !== p) n++;
            if (v !== x && v !== y) ok = 0;
            p = v;
        end
        checks++;
        if (!ok || n > tg || n + 1 < tg) begin
            err_total++;
            $display("FAIL lamp %0d.%0d exp %0d/%0d x%0d seen %0d x%0d", b, f, x, y, tg, v, n);
        end
    endtask
    task automatic t_grace();
        base();
        nc.link_all_up = 1'b0;
        nc.link_absent = 1'b1;
        nc.net_all_up = 1'b0;
        nc.net_absent = 1'b1;
        see(0, 0, G, O, 6);
        see(1, 0, G, O, 6);
        see(1, 1, R, O, 6);
        chk("link rec", lrec[0], 1'b0);
        chk("net rec", nrec[1], 1'b0);
        chk("big link rec", lrec[1], 1'b0);
        for (int k = 0; k < 200 && grc[0] !== 1'b0; k++) @(posedge clk);
        @(negedge clk);
        chk("link rec late", lrec[0], 1'b1);
        chk("net rec late", nrec[1], 1'b1);
        chk("big link rec late", lrec[1], 1'b1);
        $display("t_grace done");
    endtask
    task automatic t_link();
        base();
        see(0, 0, G, G, 0);
        see(1, 0, G, G, 0);
        see(1, 1, G, G, 0);
        nc.link_all_up = 1'b0;
        nc.net_all_up = 1'b0;
        see(0, 0, G, O, 6);
        see(1, 1, G, O, 6);
        nc.link_comm_err = 1'b1;
        nc.net_comm_err = 1'b1;
        see(1, 0, R, O, 6);
        see(1, 1, R, O, 6);
        base();
        nc.prog_err = 1'b1;
        see(0, 0, R, O, 6);
        base();
        nc.app_minor = 1'b1;
        see(0, 0, R, O, 6);
        base();
        ns.app_stored = 1'b0;
        see(0, 0, G, R, 6);
        base();
        nc.link_used = 1'b0;
        nc.net_used = 1'b0;
        see(1, 0, O, O, 0);
        see(1, 1, O, O, 0);
        base();
        ns.fatal = 1'b1;
        ns.validated = 1'b1;
        see(0, 0, O, O, 0);
        see(0, 5, O, O, 0);
        $display("t_link done");
    endtask
    task automatic t_modes();
        base();
        ns.validated = 1'b1;
        see(0, 3, G, G, 0);
        see(0, 2, G, G, 0);
        see(0, 5, Y, Y, 0);
        ns.mode = sld_pkg::MODE_INIT;
        see(0, 3, G, O, 6);
        see(0, 2, G, O, 3);
        ns.mode = sld_pkg::MODE_PROGRAM;
        see(0, 3, O, O, 0);
        ns.mode = sld_pkg::MODE_DEBUG;
        see(0, 4, Y, Y, 0);
        see(0, 3, O, O, 0);
        ns.debug_exec = 1'b1;
        see(0, 3, G, G, 0);
        ns.mode = sld_pkg::MODE_WAIT;
        see(0, 2, O, O, 0);
        base();
        ns.alloc_dl = 1'b1;
        see(0, 2, G, O, 3);
        nu.bp_comm = 1'b1;
        see(0, 2, R, O, 6);
        nu.watchdog_timeout = 1'b1;
        see(0, 2, R, R, 0);
        nu = '0;
        nu.alloc_err = 1'b1;
        see(0, 2, R, O, 6);
        nu = '0;
        nu.bp_minor = 1'b1;
        see(0, 2, R, O, 6);
        nu = '0;
        nu.critical = 1'b1;
        see(0, 2, R, R, 0);
        nu = '0;
        nu.hw_error = 1'b1;
        see(0, 2, R, R, 0);
        $display("t_modes done");
    endtask
    initial begin
        clk = 1'b0;
        rst = 1'b1;
        err_total = 0;
        checks = 0;
        base();
        st = ns;
        ue = nu;
        cm = nc;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        t_grace();
        t_link();
        t_modes();
        tally_and_finish();
    end
    initial begin
        #(3000 * 100);
        err_total++;
        tally_and_finish();
    end
endmodule
`default_nettype wire
